// ### hdl/bertpc_regs.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * receive bit error-rate tester. Assumes inclusion by bare name.
 */
`ifndef BERTPC_REGS_SVH
`define BERTPC_REGS_SVH

`define BERTPC_OFF_CTRL0 12'h500
`define BERTPC_OFF_CTRL1 12'h504
`define BERTPC_OFF_PAT_LO 12'h508
`define BERTPC_OFF_PAT_HI 12'h50c
`define BERTPC_OFF_BC_LO 12'h510
`define BERTPC_OFF_BC_HI 12'h514
`define BERTPC_OFF_EC_LO 12'h518
`define BERTPC_OFF_EC_HI 12'h51c

`define BERTPC_RST16 16'h0000
`define BERTPC_CTRL0_MASK 16'hef3e

`define BERTPC_C0_RESYNC 0
`define BERTPC_C0_LOAD 1
`define BERTPC_C0_PS_LSB 2
`define BERTPC_C0_RINV 5
`define BERTPC_C0_RPL_LSB 8
`define BERTPC_C0_IE_OF 13
`define BERTPC_C0_IE_BED 14
`define BERTPC_C0_IE_SYNC 15
`define BERTPC_C1_ALT_LSB 8

`define BERTPC_ST_SYNC 0
`define BERTPC_ST_ECO 1
`define BERTPC_ST_BCO 2
`define BERTPC_ST_BED 3
`define BERTPC_ST_LOCK_LOST 4
`define BERTPC_ST_RA0 5
`define BERTPC_ST_RA1 6
`define BERTPC_ST_EC_LSB 8

`define BERTPC_PS_PRBS7 3'h0
`define BERTPC_PS_PRBS11 3'h1
`define BERTPC_PS_PRBS15 3'h2
`define BERTPC_PS_QRSS 3'h3
`define BERTPC_PS_REP 3'h4
`define BERTPC_PS_ALT 3'h5

`define BERTPC_LOCK_RUN 6'h20
`define BERTPC_ERR_LIMIT 3'h6
`define BERTPC_ALL_RUN 5'h1f
`define BERTPC_ALT_MIN 8'h05
`define BERTPC_REP_LAST_BASE 5'h10

`endif

// ### hdl/bertpc_pkg.sv
/*
 * Types of the receive bit error-rate tester: synchronizer states and the
 * state records of each module. Assumes bertpc_regs.svh beside it.
 */
`default_nettype none
package bertpc_pkg;
    typedef enum logic {BERTPC_HUNT, BERTPC_LOCKED} bertpc_sync_state_t;

    typedef struct packed {
        logic [19:0] hist;
        logic [4:0] idx;
        logic [7:0] rep;
        logic word_hi;
    } bertpc_pat_st_t;

    typedef struct packed {
        bertpc_sync_state_t state;
        logic [5:0] run;
        logic [5:0] win;
        logic [2:0] errs;
        logic hunt_start;
    } bertpc_sync_st_t;

    typedef struct packed {
        logic [15:0] ctrl0;
        logic [7:0] alt_cnt;
        logic [31:0] pat;
        logic [31:0] bit_cnt;
        logic [23:0] err_cnt;
        logic [31:0] bit_lat;
        logic [23:0] err_lat;
        logic eco;
        logic bco;
        logic bed;
        logic lock_lost;
        logic ra0;
        logic ra1;
        logic lock_chg;
        logic lock_q;
        logic resync_p;
        logic [4:0] zero_run;
        logic [4:0] one_run;
        logic [15:0] rd_data;
        logic irq;
    } bertpc_top_st_t;
endpackage : bertpc_pkg
`default_nettype wire

// ### hdl/bertpc_pattern.sv
/*
 * Expected-bit source for the receive checker: PRBS history, repetitive
 * and alternating word walks over the 32-bit pattern store.
 * Assumes one bit_en pulse per received bit and a slip request from the
 * synchronizer while hunting.
 */
`default_nettype none
`include "bertpc_regs.svh"
module bertpc_pattern (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] mode,
    input wire logic [31:0] pattern,
    input wire logic [3:0] rpl,
    input wire logic [7:0] alt_count,
    input wire logic bit_en,
    input wire logic rx_bit,
    input wire logic locked,
    input wire logic slip,
    output logic expected,
    output logic legal
);
    import bertpc_pkg::*;

    bertpc_pat_st_t s_reg;
    bertpc_pat_st_t s_next;
    logic prbs_raw;
    logic [7:0] alt_last;

    function automatic logic [4:0] bertpc_wrap(input logic [4:0] idx, input logic [4:0] last);
        bertpc_wrap = (idx == last) ? 5'h00 : 5'(idx + 5'h01);
    endfunction : bertpc_wrap

    always_comb
    begin
        s_next = s_reg;
        prbs_raw = 1'b0;
        expected = 1'b0;
        legal = (mode <= `BERTPC_PS_ALT);
        alt_last = 8'((alt_count < `BERTPC_ALT_MIN ? `BERTPC_ALT_MIN : alt_count) - 8'h01);
        case (mode)
            `BERTPC_PS_PRBS7: prbs_raw = s_reg.hist[6] ^ s_reg.hist[5];
            `BERTPC_PS_PRBS11: prbs_raw = s_reg.hist[10] ^ s_reg.hist[8];
            `BERTPC_PS_PRBS15: prbs_raw = s_reg.hist[14] ^ s_reg.hist[13];
            `BERTPC_PS_QRSS: prbs_raw = s_reg.hist[19] ^ s_reg.hist[16];
            default: prbs_raw = 1'b0;
        endcase
        case (mode)
            `BERTPC_PS_REP: expected = pattern[s_reg.idx];
            `BERTPC_PS_ALT: expected = pattern[{s_reg.word_hi, s_reg.idx[3:0]}];
            default: expected = prbs_raw;
        endcase
        if (mode == `BERTPC_PS_QRSS && s_reg.hist[13:0] == 14'h0000)
        begin
            expected = 1'b1;
        end
        if (bit_en)
        begin
            s_next.hist = {s_reg.hist[18:0], locked ? prbs_raw : rx_bit};
            if (!slip && mode == `BERTPC_PS_REP)
            begin
                s_next.idx = bertpc_wrap(s_reg.idx, 5'(`BERTPC_REP_LAST_BASE + {1'b0, rpl}));
            end
            else if (!slip && mode == `BERTPC_PS_ALT)
            begin
                s_next.idx = bertpc_wrap({1'b0, s_reg.idx[3:0]}, 5'h0f);
                if (s_reg.idx[3:0] == 4'hf)
                begin
                    s_next.rep = (s_reg.rep >= alt_last) ? 8'h00 : 8'(s_reg.rep + 8'h01);
                    s_next.word_hi = (s_reg.rep >= alt_last) ? ~s_reg.word_hi : s_reg.word_hi;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
endmodule : bertpc_pattern
`default_nettype wire

// ### hdl/bertpc_sync.sv
/*
 * Receive synchronizer: hunts for 32 matching bits, then watches 64-bit
 * windows for six or more errors. Assumes mismatch is valid with bit_en.
 */
`default_nettype none
`include "bertpc_regs.svh"
module bertpc_sync (
    input wire logic clk,
    input wire logic srst,
    input wire logic bit_en,
    input wire logic mismatch,
    input wire logic legal,
    input wire logic resync,
    output logic locked,
    output logic hunt_start,
    output logic slip
);
    import bertpc_pkg::*;

    bertpc_sync_st_t s_reg;
    bertpc_sync_st_t s_next;
    logic [2:0] errs_sum;

    assign locked = (s_reg.state == BERTPC_LOCKED);
    assign hunt_start = s_reg.hunt_start;

    always_comb
    begin
        s_next = s_reg;
        s_next.hunt_start = 1'b0;
        slip = 1'b0;
        errs_sum = 3'(s_reg.errs + {2'b00, mismatch});
        case (s_reg.state)
            BERTPC_HUNT:
            begin
                if (bit_en && legal)
                begin
                    if (mismatch)
                    begin
                        s_next.run = 6'h00;
                        slip = 1'b1;
                    end
                    else if (6'(s_reg.run + 6'h01) == `BERTPC_LOCK_RUN)
                    begin
                        s_next.state = BERTPC_LOCKED;
                        s_next.win = 6'h00;
                        s_next.errs = 3'h0;
                    end
                    else
                    begin
                        s_next.run = 6'(s_reg.run + 6'h01);
                    end
                end
            end
            BERTPC_LOCKED:
            begin
                if (bit_en)
                begin
                    s_next.win = 6'(s_reg.win + 6'h01);
                    if (errs_sum >= `BERTPC_ERR_LIMIT)
                    begin
                        s_next.state = BERTPC_HUNT;
                        s_next.run = 6'h00;
                        s_next.hunt_start = 1'b1;
                    end
                    else
                    begin
                        s_next.errs = (s_reg.win == 6'h3f) ? 3'h0 : errs_sum;
                    end
                end
            end
            default: s_next.state = BERTPC_HUNT;
        endcase
        if (resync || !legal)
        begin
            s_next.hunt_start = resync || (s_reg.state == BERTPC_LOCKED);
            s_next.state = BERTPC_HUNT;
            s_next.run = 6'h00;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_reg <= '{state: BERTPC_HUNT, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    property p_lock_after_run;
        @(posedge clk) disable iff (srst)
        (s_reg.state == BERTPC_HUNT && s_reg.run == 6'h1f && bit_en && legal && !mismatch
            && !resync) |=> locked;
    endproperty
    a_lock_after_run: assert property (p_lock_after_run) else $error("no lock after 32 matches");

    property p_drop_on_errors;
        @(posedge clk) disable iff (srst)
        (locked && s_reg.errs == 3'h5 && bit_en && mismatch) |=> (!locked && hunt_start);
    endproperty
    a_drop_on_errors: assert property (p_drop_on_errors) else $error("lock kept at six errors");
endmodule : bertpc_sync
`default_nettype wire

// ### hdl/bertpc_top.sv
/*
 * Receive bit error-rate tester: bit and error counters, sticky status,
 * pattern store and control registers on a plain register port.
 * Assumes rx_bit_en pulses once per received bit, synchronous to clk, and
 * that software strobes are single cycles with read data one cycle later.
 */
// Strobed register access was chosen for this implementation.
`default_nettype none
`include "bertpc_regs.svh"
module bertpc_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic rx_bit,
    input wire logic rx_bit_en,
    output logic lock_status,
    output logic irq_req
);
    import bertpc_pkg::*;

    bertpc_top_st_t s_reg;
    bertpc_top_st_t s_next;
    logic rx_eff;
    logic expected;
    logic legal;
    logic locked;
    logic hunt_start;
    logic slip;
    logic mismatch;
    logic load_edge;
    logic rd_status;
    logic [15:0] status_word;

    assign reg_rdata = s_reg.rd_data;
    assign lock_status = s_reg.lock_q;
    assign irq_req = s_reg.irq;
    assign rx_eff = rx_bit ^ s_reg.ctrl0[`BERTPC_C0_RINV];
    assign mismatch = rx_bit_en && legal && (rx_eff != expected);
    assign load_edge = reg_wr && reg_addr == `BERTPC_OFF_CTRL0
        && reg_wdata[`BERTPC_C0_LOAD] && !s_reg.ctrl0[`BERTPC_C0_LOAD];
    assign rd_status = reg_rd && reg_addr == `BERTPC_OFF_EC_LO;

    bertpc_pattern u_pattern (
        .clk(clk),
        .srst(srst),
        .mode(s_reg.ctrl0[`BERTPC_C0_PS_LSB +: 3]),
        .pattern(s_reg.pat),
        .rpl(s_reg.ctrl0[`BERTPC_C0_RPL_LSB +: 4]),
        .alt_count(s_reg.alt_cnt),
        .bit_en(rx_bit_en),
        .rx_bit(rx_eff),
        .locked(locked),
        .slip(slip),
        .expected(expected),
        .legal(legal)
    );

    bertpc_sync u_sync (
        .clk(clk),
        .srst(srst),
        .bit_en(rx_bit_en),
        .mismatch(mismatch),
        .legal(legal),
        .resync(s_reg.resync_p),
        .locked(locked),
        .hunt_start(hunt_start),
        .slip(slip)
    );

    always_comb
    begin
        s_next = s_reg;
        status_word = {s_reg.err_lat[7:0], 1'b0, s_reg.ra1, s_reg.ra0, s_reg.lock_lost, s_reg.bed,
            s_reg.bco, s_reg.eco, s_reg.lock_q};
        s_next.resync_p = 1'b0;
        s_next.lock_q = locked;
        // Register writes; the pattern store is taken as the host leaves it
        if (reg_wr)
        begin
            case (reg_addr)
                `BERTPC_OFF_CTRL0:
                begin
                    s_next.ctrl0 = reg_wdata & `BERTPC_CTRL0_MASK;
                    s_next.resync_p = reg_wdata[`BERTPC_C0_RESYNC]
                        && !s_reg.ctrl0[`BERTPC_C0_RESYNC];
                end
                `BERTPC_OFF_CTRL1: s_next.alt_cnt = reg_wdata[`BERTPC_C1_ALT_LSB +: 8];
                `BERTPC_OFF_PAT_LO: s_next.pat[15:0] = reg_wdata;
                `BERTPC_OFF_PAT_HI: s_next.pat[31:16] = reg_wdata;
                default: s_next.ctrl0 = s_reg.ctrl0;
            endcase
        end
        // Read data stands in the cycle after the strobe only
        s_next.rd_data = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `BERTPC_OFF_CTRL0: s_next.rd_data = s_reg.ctrl0;
                `BERTPC_OFF_CTRL1: s_next.rd_data = {s_reg.alt_cnt, 8'h00};
                `BERTPC_OFF_PAT_LO: s_next.rd_data = s_reg.pat[15:0];
                `BERTPC_OFF_PAT_HI: s_next.rd_data = s_reg.pat[31:16];
                `BERTPC_OFF_BC_LO: s_next.rd_data = s_reg.bit_lat[15:0];
                `BERTPC_OFF_BC_HI: s_next.rd_data = s_reg.bit_lat[31:16];
                `BERTPC_OFF_EC_LO: s_next.rd_data = status_word;
                `BERTPC_OFF_EC_HI: s_next.rd_data = s_reg.err_lat[23:8];
                default: s_next.rd_data = 16'h0000;
            endcase
        end
        // Status read clears the sticky flags, ra0/ra1 only once their run has ended; set events below win
        if (rd_status)
        begin
            s_next.eco = 1'b0;
            s_next.bco = 1'b0;
            s_next.bed = 1'b0;
            s_next.lock_lost = 1'b0;
            s_next.lock_chg = 1'b0;
            if (s_reg.zero_run == 5'h00)
            begin
                s_next.ra0 = 1'b0;
            end
            if (s_reg.one_run == 5'h00)
            begin
                s_next.ra1 = 1'b0;
            end
        end
        // Counters run regardless of lock
        if (rx_bit_en)
        begin
            if (s_reg.bit_cnt == 32'hffffffff)
            begin
                s_next.bco = 1'b1;
            end
            else
            begin
                s_next.bit_cnt = 32'(s_reg.bit_cnt + 32'h00000001);
            end
            if (mismatch)
            begin
                if (s_reg.err_cnt == 24'hffffff)
                begin
                    s_next.eco = 1'b1;
                end
                else
                begin
                    s_next.err_cnt = 24'(s_reg.err_cnt + 24'h000001);
                end
                if (locked)
                begin
                    s_next.bed = 1'b1;
                end
            end
            s_next.zero_run = rx_eff ? 5'h00 :
                (s_reg.zero_run == `BERTPC_ALL_RUN ? s_reg.zero_run : 5'(s_reg.zero_run + 5'h01));
            s_next.one_run = !rx_eff ? 5'h00 :
                (s_reg.one_run == `BERTPC_ALL_RUN ? s_reg.one_run : 5'(s_reg.one_run + 5'h01));
            if (!rx_eff && s_reg.zero_run == 5'(`BERTPC_ALL_RUN - 5'h01))
            begin
                s_next.ra0 = 1'b1;
            end
            if (rx_eff && s_reg.one_run == 5'(`BERTPC_ALL_RUN - 5'h01))
            begin
                s_next.ra1 = 1'b1;
            end
        end
        if (hunt_start)
        begin
            s_next.lock_lost = 1'b1;
        end
        if (locked != s_reg.lock_q)
        begin
            s_next.lock_chg = 1'b1;
        end
        // Load edge: copy running counts, restart them with this cycle's bit
        if (load_edge)
        begin
            s_next.bit_lat = s_reg.bit_cnt;
            s_next.err_lat = s_reg.err_cnt;
            s_next.bit_cnt = {31'h00000000, rx_bit_en};
            s_next.err_cnt = {23'h000000, mismatch};
        end
        s_next.irq = (s_reg.ctrl0[`BERTPC_C0_IE_OF] && (s_reg.eco || s_reg.bco))
            || (s_reg.ctrl0[`BERTPC_C0_IE_BED] && s_reg.bed)
            || (s_reg.ctrl0[`BERTPC_C0_IE_SYNC] && s_reg.lock_chg);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    property p_bit_count;
        @(posedge clk) disable iff (srst)
        (rx_bit_en && !load_edge && s_reg.bit_cnt != 32'hffffffff)
            |=> s_reg.bit_cnt == 32'($past(s_reg.bit_cnt) + 32'h00000001);
    endproperty
    a_bit_count: assert property (p_bit_count) else $error("bit count did not advance");

    property p_count_unlocked;
        @(posedge clk) disable iff (srst)
        (!locked && rx_bit_en && mismatch && !load_edge && s_reg.err_cnt != 24'hffffff)
            |=> s_reg.err_cnt == 24'($past(s_reg.err_cnt) + 24'h000001);
    endproperty
    a_count_unlocked: assert property (p_count_unlocked) else $error("count stalled out of lock");

    property p_bit_sat;
        @(posedge clk) disable iff (srst)
        (s_reg.bit_cnt == 32'hffffffff && rx_bit_en && !load_edge)
            |=> (s_reg.bit_cnt == 32'hffffffff && s_reg.bco);
    endproperty
    a_bit_sat: assert property (p_bit_sat) else $error("bit counter wrapped");

    property p_err_sat;
        @(posedge clk) disable iff (srst)
        (s_reg.err_cnt == 24'hffffff && mismatch && !load_edge)
            |=> (s_reg.err_cnt == 24'hffffff && s_reg.eco);
    endproperty
    a_err_sat: assert property (p_err_sat) else $error("error counter wrapped");

    property p_load;
        @(posedge clk) disable iff (srst)
        load_edge |=> (s_reg.bit_lat == $past(s_reg.bit_cnt)
            && s_reg.err_lat == $past(s_reg.err_cnt) && s_reg.err_cnt <= 24'h000001);
    endproperty
    a_load: assert property (p_load) else $error("load edge did not capture");

    property p_lat_hold;
        @(posedge clk) disable iff (srst)
        !load_edge |=> $stable(s_reg.bit_lat);
    endproperty
    a_lat_hold: assert property (p_lat_hold) else $error("host copy changed without load");

    property p_bed_locked;
        @(posedge clk) disable iff (srst)
        $rose(s_reg.bed) |-> $past(locked);
    endproperty
    a_bed_locked: assert property (p_bed_locked) else $error("mismatch flag set out of lock");

    property p_set_wins;
        @(posedge clk) disable iff (srst)
        (rd_status && hunt_start) |=> s_reg.lock_lost;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost to read");

    property p_all_zeros;
        @(posedge clk) disable iff (srst)
        (rx_bit_en && !rx_eff && s_reg.zero_run == 5'h1e) |=> s_reg.ra0 ##1 s_reg.ra0 || rx_bit_en;
    endproperty
    a_all_zeros: assert property (p_all_zeros) else $error("all zeros flag missed");

    property p_irq_gate;
        @(posedge clk) disable iff (srst)
        s_reg.irq |-> ($past(s_reg.ctrl0[`BERTPC_C0_IE_OF]) || $past(s_reg.ctrl0[`BERTPC_C0_IE_BED])
            || $past(s_reg.ctrl0[`BERTPC_C0_IE_SYNC]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised while masked");
endmodule : bertpc_top
`default_nettype wire

// ### tb/bertpc_src.sv
/*
 * Far-side bit source: repeats a 32-bit pattern, bit 0 first, or sends a
 * constant level, flipping every other bit while an error budget lasts.
 * Assumes the same clock as the tester and one go pulse per burst.
 */
`default_nettype none
module bertpc_src (
    input wire logic clk,
    input wire logic srst,
    input wire logic go,
    input wire logic [11:0] nbits,
    input wire logic [7:0] nerr,
    input wire logic [1:0] gap,
    input wire logic cst_en,
    input wire logic cst_val,
    input wire logic [31:0] pattern,
    output logic rx_bit,
    output logic rx_bit_en,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] left;
    logic [7:0] eleft;
    logic [4:0] idx;
    logic [1:0] wait_cnt;
    logic flip;
    wire logic hit = flip && (eleft != 8'h00);
    wire logic nb = (cst_en ? cst_val : pattern[idx]) ^ hit;
    assign busy = left != 12'h000;
    always_ff @(posedge clk)
    begin
        rx_bit_en <= 1'b0;
        // Line is not held between bits
        rx_bit <= ~rx_bit;
        if (srst)
        begin
            left <= 12'h000;
            eleft <= 8'h00;
            idx <= 5'h00;
            wait_cnt <= 2'h0;
            flip <= 1'b0;
            rx_bit <= 1'b0;
        end
        else if (go)
        begin
            left <= nbits;
            eleft <= nerr;
            wait_cnt <= gap;
            flip <= 1'b0;
        end
        else if (busy && wait_cnt != 2'h0)
            wait_cnt <= wait_cnt - 2'h1;
        else if (busy)
        begin
            rx_bit <= nb;
            rx_bit_en <= 1'b1;
            idx <= idx + 5'h01;
            left <= left - 12'h001;
            wait_cnt <= gap;
            flip <= ~flip;
            if (hit)
                eleft <= eleft - 8'h01;
        end
    end
endmodule : bertpc_src
`default_nettype wire

// ### tb/tb.sv
/*
 * Self-checking bench of the bit error-rate tester: register master,
 * bit source partner, counters, lock and sticky flags.
 * Assumes the bit source model and the register header beside it.
 */
`default_nettype none
`include "bertpc_regs.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic rx_bit, rx_bit_en, lock_status, irq_req, busy;
    logic go = 1'b0;
    logic cst_en = 1'b0;
    logic cst_val = 1'b0;
    logic [11:0] nbits = 12'h000;
    logic [7:0] nerr = 8'h00;
    logic [1:0] gap = 2'h0;
    logic [31:0] pat = 32'h0000_0000;
    logic [15:0] d;
    logic saw_unlock = 1'b0;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    bertpc_top dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_bit(rx_bit),
        .rx_bit_en(rx_bit_en), .lock_status(lock_status), .irq_req(irq_req));
    bertpc_src src (.clk(clk), .srst(srst), .go(go), .nbits(nbits), .nerr(nerr),
        .gap(gap), .cst_en(cst_en), .cst_val(cst_val), .pattern(pat),
        .rx_bit(rx_bit), .rx_bit_en(rx_bit_en), .busy(busy));
    function automatic logic [15:0] c0(input logic [2:0] ps, input logic load);
        return {1'b1, 3'h0, 4'hf, 3'h0, ps, load, 1'b0};
    endfunction : c0
    task automatic results();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic send(input int n, input int e, input logic c, input logic v);
        int k;
        @(posedge clk);
        go <= 1'b1;
        nbits <= 12'(n);
        nerr <= 8'(e);
        cst_en <= c;
        cst_val <= v;
        gap <= 2'($urandom_range(0, 3));
        @(posedge clk);
        go <= 1'b0;
        #1;
        k = 0;
        while (busy === 1'b1 && k < 20000)
        begin
            @(posedge clk);
            k++;
        end
        repeat (4) @(posedge clk);
        #1;
    endtask : send
    always @(posedge clk)
    begin
        cycles++;
        if (lock_status === 1'b0)
            saw_unlock <= 1'b1;
        if (cycles >= 30000)
        begin
            n_mismatch++;
            $display("unexpected at %0t: run too long", $time);
            results();
        end
    end
    initial
    begin
        logic [15:0] v;
        int i;
        void'($urandom(32'he5f1));
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (i = 0; i < 7; i++)
        begin
            rd(12'h508 + 12'(4 * i));
            `CHK(d, `BERTPC_RST16)
        end
        v = 16'($urandom);
        wr(`BERTPC_OFF_CTRL0, v);
        rd(`BERTPC_OFF_CTRL0);
        `CHK(d, v & `BERTPC_CTRL0_MASK)
        pat = $urandom;
        wr(`BERTPC_OFF_PAT_LO, pat[15:0]);
        wr(`BERTPC_OFF_PAT_HI, pat[31:16]);
        rd(`BERTPC_OFF_PAT_HI);
        `CHK(d, pat[31:16])
        wr(`BERTPC_OFF_CTRL0, c0(`BERTPC_PS_REP, 1'b0));
        send(2000, 0, 1'b0, 1'b0);
        `CHK(lock_status, 1'b1)
        `CHK(irq_req, 1'b1)
        rd(`BERTPC_OFF_EC_LO);
        `CHK(d[`BERTPC_ST_SYNC], 1'b1)
        repeat (2) @(posedge clk);
        #1;
        `CHK(irq_req, 1'b0)
        wr(`BERTPC_OFF_CTRL0, c0(`BERTPC_PS_REP, 1'b1));
        wr(`BERTPC_OFF_CTRL0, c0(`BERTPC_PS_REP, 1'b0));
        send(100, 3, 1'b0, 1'b0);
        rd(`BERTPC_OFF_BC_LO);
        `CHK(d, 16'h07d0)
        wr(`BERTPC_OFF_CTRL0, c0(`BERTPC_PS_REP, 1'b1));
        rd(`BERTPC_OFF_BC_LO);
        `CHK(d, 16'h0064)
        rd(`BERTPC_OFF_BC_HI);
        `CHK(d, 16'h0000)
        rd(`BERTPC_OFF_EC_LO);
        `CHK(d[15:8], 8'h03)
        `CHK(d[`BERTPC_ST_BED], 1'b1)
        `CHK(d[`BERTPC_ST_LOCK_LOST], 1'b0)
        rd(`BERTPC_OFF_EC_HI);
        `CHK(d, 16'h0000)
        wr(`BERTPC_OFF_CTRL0, c0(`BERTPC_PS_REP, 1'b0));
        saw_unlock <= 1'b0;
        send(24, 12, 1'b0, 1'b0);
        send(2000, 0, 1'b0, 1'b0);
        `CHK(saw_unlock, 1'b1)
        `CHK(lock_status, 1'b1)
        rd(`BERTPC_OFF_EC_LO);
        `CHK(d[`BERTPC_ST_LOCK_LOST], 1'b1)
        rd(`BERTPC_OFF_EC_LO);
        `CHK(d[`BERTPC_ST_LOCK_LOST], 1'b0)
        `CHK(d[`BERTPC_ST_BED], 1'b0)
        wr(`BERTPC_OFF_CTRL0, c0(3'h6, 1'b0));
        send(100, 0, 1'b0, 1'b0);
        `CHK(lock_status, 1'b0)
        wr(`BERTPC_OFF_CTRL0, c0(`BERTPC_PS_REP, 1'b0));
        for (i = 0; i < 2; i++)
        begin
            send(1, 0, 1'b1, ~i[0]);
            send(30, 0, 1'b1, i[0]);
            rd(`BERTPC_OFF_EC_LO);
            `CHK(d[5 + i], 1'b0)
            send(1, 0, 1'b1, i[0]);
            rd(`BERTPC_OFF_EC_LO);
            `CHK(d[5 + i], 1'b1)
            rd(`BERTPC_OFF_EC_LO);
            `CHK(d[5 + i], 1'b1)
            send(1, 0, 1'b1, ~i[0]);
            rd(`BERTPC_OFF_EC_LO);
            `CHK(d[5 + i], 1'b1)
            rd(`BERTPC_OFF_EC_LO);
            `CHK(d[5 + i], 1'b0)
        end
        v = {8'($urandom), 8'h00};
        wr(`BERTPC_OFF_CTRL1, v);
        rd(`BERTPC_OFF_CTRL1);
        `CHK(d, v)
        wr(`BERTPC_OFF_PAT_LO, 16'hffff);
        wr(`BERTPC_OFF_PAT_HI, 16'hffff);
        rd(`BERTPC_OFF_PAT_LO);
        `CHK(d, 16'hffff)
        results();
    end
endmodule : tb
`default_nettype wire
